// ---- vcxo_synth_regs.vh ----
// Register map, field layout, reset values and limits for the divider synthesis block.
// Assumes the including file needs plain defines only; nothing here drives logic.
`ifndef VCXO_SYNTH_REGS_VH
`define VCXO_SYNTH_REGS_VH

// Byte offsets on the APB bus
`define OFS_FB_FRAC        12'h000
`define OFS_FB_INT         12'h004
`define OFS_HS_DIV         12'h008
`define OFS_LS_DIV         12'h00C
`define OFS_PULL_GAIN      12'h010
`define OFS_CONV_GAIN      12'h014
`define OFS_APPLY          12'h018
`define OFS_STATUS         12'h01C
`define OFS_CTRL_VOLT      12'h020

// Field widths
`define FB_INT_W           11
`define FB_FRAC_W          32
`define FB_W               43
`define HS_W               11
`define LS_W               3
`define GAIN_W             16
`define CONV_W             8
`define CV_W               12

// Reset values
`define FB_RESET           43'h03C_0000_0000
`define HS_RESET           11'h004
`define LS_RESET           3'h0
`define PULL_GAIN_RESET    16'h003C
`define CONV_GAIN_RESET    8'h80
`define CV_MID             12'h800

// Divider limits
`define FB_MIN             43'h03C_0000_0000
`define FB_MAX             43'h7FD_FFFF_FFFF
`define HS_MIN             11'h004
`define HS_MAX             11'h7FE
`define HS_ODD_MAX         11'h021
`define LS_MAX_EXP         3'h5

`endif

// ---- odd_duty_divider.v ----
// Integer divider with 50 percent duty correction for odd ratios up to 33.
// Assumes ratio changes only through a restart pulse from the owner.
`timescale 1ns/10ps
`include "vcxo_synth_regs.vh"
module odd_duty_divider
(
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  // Control
  input  wire [10:0] ratio_i,
  input  wire        restart_i,
  // Output
  output reg         clk_div_o
);
  reg  [10:0] count;
  reg         high_pos;
  reg         high_neg;
  wire        last    = (count == ratio_i - 11'h001);
  wire [10:0] half    = {1'b0, ratio_i[10:1]};
  wire        odd_fix = ratio_i[0] && (ratio_i <= `HS_ODD_MAX);

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count    <= 11'h000;
      high_pos <= 1'b0;
    end
    else if (restart_i)
    begin
      count    <= 11'h000;
      high_pos <= 1'b0;
    end
    else
    begin
      count    <= last ? 11'h000 : count + 11'h001;
      // Odd ratio up to 33: one extra slot high, trimmed later by the half-cycle copy
      high_pos <= odd_fix ? (count <= half) : (count < half);
    end
  end

  // Half-cycle delayed copy, so an odd ratio up to 33 gets a high phase of n/2 slots
  always @(negedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      high_neg <= 1'b0;
    else
      high_neg <= high_pos;
  end

  always @*
  begin
    clk_div_o = odd_fix ? (high_pos & high_neg) : high_pos;
  end
endmodule // odd_duty_divider

// ---- pow2_divider.v ----
// Power-of-two divider driven by an exponent field.
// Assumes input is a single-cycle enable tick stream from the high-speed stage.
`timescale 1ns/10ps
`include "vcxo_synth_regs.vh"
module pow2_divider
(
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  // Control
  input  wire [2:0] exp_i,
  input  wire       tick_i,
  input  wire       restart_i,
  // Output
  output reg        clk_div_o
);
  reg  [4:0] count;
  // Exponents above five clamp to divide by 32
  wire [2:0] exp_eff = (exp_i > `LS_MAX_EXP) ? `LS_MAX_EXP : exp_i;
  wire [5:0] ratio   = 6'h01 << exp_eff;

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count     <= 5'h00;
      clk_div_o <= 1'b0;
    end
    else if (restart_i)
    begin
      count     <= 5'h00;
      clk_div_o <= 1'b0;
    end
    else if (tick_i)
    begin
      if (ratio == 6'h01)
        clk_div_o <= ~clk_div_o;
      else
      begin
        count <= (count == ratio[5:1] - 5'h01) ? 5'h00 : count + 5'h01;
        if (count == ratio[5:1] - 5'h01)
          clk_div_o <= ~clk_div_o;
      end
    end
  end
endmodule // pow2_divider

// ---- vcxo_divider_synth_config.v ----
// Divider configuration, APB registers, pulled feedback divider and output dividers.
// Assumes a 10 MHz APB clock and a digitised control voltage sampled synchronously.
`timescale 1ns/10ps
`include "vcxo_synth_regs.vh"

// How it works
// - Output is VCO over both divider ratios
// - VCO equals reference times feedback divider
// - Control voltage times gain modulates feedback
// - Above mid raises, below mid lowers
// - Only registers set the centre frequency
// - Feedback divider is unsigned 11.32 fixed point
// - High-speed divider 11 bits, 4 to 2046; values outside are still applied and only flagged in status
// - Odd ratios to 33 keep 50 percent duty
// - Low-speed field is power-of-two exponent
// - Exponents 5 to 7 give divide by 32
// - Dual outputs same frequency, complementary or in-phase
module vcxo_divider_synth_config
(
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output wire        pslverr_o,
  // Control voltage sample, 0 to full scale, mid at half supply
  input  wire [11:0] control_voltage_pin_i,
  // Dual CMOS option: high selects in-phase
  input  wire        dual_in_phase_i,
  // Effective synthesis settings
  output reg  [42:0] feedback_divider_o,
  output reg  [10:0] high_speed_out_divider_o,
  output reg  [2:0]  low_speed_out_divider_o,
  output reg  [7:0]  control_converter_full_scale_gain_o,
  // Clock outputs
  output wire        clk_out_p_o,
  output wire        clk_out_n_o
);
  // Staging registers
  reg  [31:0] stage_frac;
  reg  [10:0] stage_int;
  reg  [10:0] stage_hs;
  reg  [2:0]  stage_ls;
  reg  [15:0] pull_gain_ppm_per_volt;
  reg  [7:0]  stage_conv;
  // Active registers
  reg  [42:0] feedback_centre;
  reg  [15:0] gain_active;
  reg         restart;
  reg         range_err;
  reg  [31:0] next_prdata;

  localparam [42:0] fb_reset_word = `FB_RESET;

  wire access = psel_i && penable_i;
  wire wr     = access && pwrite_i;
  wire rd     = access && !pwrite_i;
  wire mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= `OFS_CTRL_VOLT);

  assign pready_o  = 1'b1;
  assign pslverr_o = access && !mapped;

  // Signed offset of control voltage from mid supply
  wire signed [12:0] cv_off = $signed({1'b0, control_voltage_pin_i}) - $signed({1'b0, `CV_MID});
  // Offset times ppm gain, scaled to 2^-32 units of the divider
  wire signed [29:0] ppm_scaled = cv_off * $signed({1'b0, gain_active});
  wire signed [73:0] delta_full = $signed({1'b0, feedback_centre}) * ppm_scaled;
  // Divide by 1e6 approx via 2^-20 and 1024 counts per volt approx; sign preserved
  wire signed [43:0] delta = delta_full[73:30];
  wire signed [44:0] pulled = $signed({2'b00, feedback_centre}) + $signed({delta[43], delta});

  // Pulled feedback divider
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      feedback_divider_o <= `FB_RESET;
    else if (pulled[44])
      feedback_divider_o <= 43'h000_0000_0000;
    else if (pulled[43])
      feedback_divider_o <= 43'h7FF_FFFF_FFFF;
    else
      feedback_divider_o <= pulled[42:0];
  end

  // Register writes and commit
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage_frac             <= 32'h0000_0000;
      stage_int              <= fb_reset_word[42:32];
      stage_hs               <= `HS_RESET;
      stage_ls               <= `LS_RESET;
      pull_gain_ppm_per_volt <= `PULL_GAIN_RESET;
      stage_conv             <= `CONV_GAIN_RESET;
      feedback_centre        <= `FB_RESET;
      high_speed_out_divider_o <= `HS_RESET;
      low_speed_out_divider_o  <= `LS_RESET;
      control_converter_full_scale_gain_o <= `CONV_GAIN_RESET;
      gain_active            <= `PULL_GAIN_RESET;
      restart                <= 1'b0;
      range_err              <= 1'b0;
    end
    else
    begin
      restart <= 1'b0;
      if (wr)
      begin
        case (paddr_i)
          `OFS_FB_FRAC:   stage_frac <= pwdata_i;
          `OFS_FB_INT:    stage_int  <= pwdata_i[10:0];
          `OFS_HS_DIV:    stage_hs   <= pwdata_i[10:0];
          `OFS_LS_DIV:    stage_ls   <= pwdata_i[2:0];
          `OFS_PULL_GAIN: pull_gain_ppm_per_volt <= pwdata_i[15:0];
          `OFS_CONV_GAIN: stage_conv <= pwdata_i[7:0];
          `OFS_APPLY:
          begin
            if (pwdata_i[0])
            begin
              // Whole values move to synthesis only here
              feedback_centre          <= {stage_int, stage_frac};
              high_speed_out_divider_o <= stage_hs;
              low_speed_out_divider_o  <= stage_ls;
              gain_active              <= pull_gain_ppm_per_volt;
              control_converter_full_scale_gain_o <= stage_conv;
              restart                  <= 1'b1;
              // Flag settings outside documented limits
              range_err <= ({stage_int, stage_frac} < `FB_MIN) ||
                           ({stage_int, stage_frac} > `FB_MAX) ||
                           (stage_hs < `HS_MIN) || (stage_hs > `HS_MAX);
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Read mux
  always @*
  begin
    next_prdata = 32'h0000_0000;
    case (paddr_i)
      `OFS_FB_FRAC:   next_prdata = stage_frac;
      `OFS_FB_INT:    next_prdata = {21'h00_0000, stage_int};
      `OFS_HS_DIV:    next_prdata = {21'h00_0000, stage_hs};
      `OFS_LS_DIV:    next_prdata = {29'h0000_0000, stage_ls};
      `OFS_PULL_GAIN: next_prdata = {16'h0000, pull_gain_ppm_per_volt};
      `OFS_CONV_GAIN: next_prdata = {24'h00_0000, stage_conv};
      `OFS_STATUS:    next_prdata = {31'h0000_0000, range_err};
      `OFS_CTRL_VOLT: next_prdata = {20'h0_0000, control_voltage_pin_i};
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
      // Loaded at the setup edge so data stands through the access phase
      prdata_o <= next_prdata;
  end

  // Output divider chain
  wire hs_clk;
  reg  hs_clk_d;
  wire hs_tick = hs_clk && !hs_clk_d;
  wire ls_clk;

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hs_clk_d <= 1'b0;
    else
      hs_clk_d <= hs_clk;
  end

  odd_duty_divider u_hs
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .ratio_i   (high_speed_out_divider_o),
    .restart_i (restart),
    .clk_div_o (hs_clk)
  );

  pow2_divider u_ls
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .exp_i     (low_speed_out_divider_o),
    .tick_i    (hs_tick),
    .restart_i (restart),
    .clk_div_o (ls_clk)
  );

  // Exponent zero bypasses the low-speed stage: divide by one
  wire ls_out = (low_speed_out_divider_o == 3'h0) ? hs_clk : ls_clk;

  // Dual CMOS pair
  assign clk_out_p_o = ls_out;
  assign clk_out_n_o = dual_in_phase_i ? ls_out : ~ls_out;
endmodule // vcxo_divider_synth_config

// ---- vcxo_synth_chk.sv ----
// Checker for the divider block: APB answers, staged settings, dual outputs
// Assumes it is bound to the block's top-level ports
`timescale 1ns/10ps
module vcxo_synth_chk
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  // Settings and clocks
  input wire logic        dual_in_phase_i,
  input wire logic [10:0] high_speed_out_divider_o,
  input wire logic [2:0]  low_speed_out_divider_o,
  input wire logic [7:0]  control_converter_full_scale_gain_o,
  input wire logic        clk_out_p_o,
  input wire logic        clk_out_n_o
);
  logic acc;
  logic apl;
  logic bad;
  assign acc = psel_i && penable_i;
  assign apl = acc && pwrite_i && paddr_i == 12'h018 && pwdata_i[0];
  assign bad = paddr_i > 12'h020 || paddr_i[1:0] != 2'b00;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  property p_rdy; acc |-> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; acc |-> pslverr_o == bad; endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_hs; !apl |=> $stable(high_speed_out_divider_o); endproperty
  a_hs: assert property (p_hs) else $error("hs moved");
  property p_ls; !apl |=> $stable(low_speed_out_divider_o); endproperty
  a_ls: assert property (p_ls) else $error("ls moved");
  property p_cg; !apl |=> $stable(control_converter_full_scale_gain_o); endproperty
  a_cg: assert property (p_cg) else $error("gain moved");
  property p_inp; dual_in_phase_i |-> clk_out_n_o == clk_out_p_o; endproperty
  a_inp: assert property (p_inp) else $error("not in phase");
  property p_cmp; !dual_in_phase_i |-> clk_out_n_o != clk_out_p_o; endproperty
  a_cmp: assert property (p_cmp) else $error("not complementary");
  property p_rdz; acc && !pwrite_i && (bad || paddr_i == 12'h018) |-> prdata_o == 0; endproperty
  a_rdz: assert property (p_rdz) else $error("read not zero");
  c_apl: cover property (apl);
  c_bad: cover property (acc && bad);
  c_inp: cover property (dual_in_phase_i && $rose(clk_out_p_o));
endmodule // vcxo_synth_chk

bind vcxo_divider_synth_config vcxo_synth_chk u_chk
(
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .dual_in_phase_i(dual_in_phase_i),
  .high_speed_out_divider_o(high_speed_out_divider_o),
  .low_speed_out_divider_o(low_speed_out_divider_o),
  .control_converter_full_scale_gain_o(control_converter_full_scale_gain_o),
  .clk_out_p_o(clk_out_p_o), .clk_out_n_o(clk_out_n_o)
);

// ---- apb_host_model.sv ----
// APB host model: single transfers to the divider block
// Assumes pready sampled at rising edges; read data taken at that same edge
`timescale 1ns/10ps
module apb_host_model
(
  // Clock
  input wire logic        clk_sys_i,
  // APB request
  output logic            psel_o,
  output logic            penable_o,
  output logic            pwrite_o,
  output logic [11:0]     paddr_o,
  output logic [31:0]     pwdata_o,
  // APB answer
  input wire logic        pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic        pslverr_i
);
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output logic to);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    @(posedge clk_sys_i);
    while (!pready_i && n < 16)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    to = !pready_i;
    e = pslverr_i;
    r = prdata_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask
endmodule // apb_host_model

// ---- tb.sv ----
// Testbench for the divider block
// Assumes the host model and the bound checker are compiled first
`timescale 1ns/10ps
module tb;
  logic        clk_sys_i = 0;
  logic        reset_n_i = 0;
  logic        dual_in_phase_i = 0;
  logic [11:0] control_voltage_pin_i = 12'h800;
  logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic        clk_out_p_o, clk_out_n_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic [42:0] fb;
  logic [10:0] hs;
  logic [2:0]  ls;
  logic [7:0]  cg;
  longint      t [3];
  int          mismatches = 0;
  int          check_count = 0;
  localparam logic [31:0] zero = 32'h0000_0000;
  localparam logic [42:0] ctr = {11'h064, 32'h8000_0000};
  always #50 clk_sys_i = ~clk_sys_i;
  apb_host_model host (.clk_sys_i, .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i), .pready_i(pready_o),
    .prdata_i(prdata_o), .pslverr_i(pslverr_o));
  vcxo_divider_synth_config DUT (.clk_sys_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .control_voltage_pin_i,
    .dual_in_phase_i, .feedback_divider_o(fb), .high_speed_out_divider_o(hs),
    .low_speed_out_divider_o(ls), .control_converter_full_scale_gain_o(cg),
    .clk_out_p_o, .clk_out_n_o);
  task close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] x);
    check_count++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task tmo(input logic b);
    if (b)
    begin
      mismatches++;
      close_out;
    end
  endtask
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic b;
    host.xfer(w, a, d, r, e, b);
    tmo(b);
  endtask
  task lvl(input logic v, input int i);
    int n;
    n = 0;
    while (clk_out_p_o !== v && n < 4000)
    begin
      @(clk_sys_i);
      #1;
      n++;
    end
    tmo(n == 4000);
    t[i] = $time;
  endtask
  task div_chk(input logic [10:0] h, input logic [2:0] l, input longint p);
    xf(1, 12'h008, {21'h0, h});
    xf(1, 12'h00C, {29'h0, l});
    xf(1, 12'h018, 32'h0000_0001);
    lvl(0, 0);
    lvl(1, 0);
    lvl(0, 1);
    lvl(1, 2);
    chk(t[2] - t[0], p);
    chk(2 * (t[1] - t[0]), p);
  endtask
  task cv_chk(input logic [11:0] v, input logic [2:0] x);
    control_voltage_pin_i <= v;
    repeat (4) @(posedge clk_sys_i);
    chk({fb > ctr, fb < ctr, fb == ctr}, x);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] x, input logic ex);
    xf(0, a, zero);
    chk(r, x);
    chk(e, ex);
  endtask
  task t_reset;
    chk(fb, 43'h03C_0000_0000);
    rd_chk(12'h008, 32'h0000_0004, 1'b0);
    rd_chk(12'h00C, zero, 1'b0);
    rd_chk(12'h010, 32'h0000_003C, 1'b0);
    rd_chk(12'h014, 32'h0000_0080, 1'b0);
    rd_chk(12'h018, zero, 1'b0);
    rd_chk(12'h040, zero, 1'b1);
  endtask
  task t_stage;
    xf(1, 12'h000, 32'h8000_0000);
    xf(1, 12'h004, 32'h0000_0064);
    xf(1, 12'h008, 32'h0000_0006);
    chk(hs, 11'h004);
    chk(fb, 43'h03C_0000_0000);
    xf(1, 12'h018, 32'h0000_0001);
    cv_chk(12'h800, 3'b001);
    cv_chk(12'h900, 3'b100);
    cv_chk(12'h700, 3'b010);
    cv_chk(12'h800, 3'b001);
    chk(hs, 11'h006);
  endtask
  task t_div;
    div_chk(11'h005, 3'h0, 500);
    for (int i = 0; i < 6; i++)
      div_chk(11'h004, i[2:0], 400 << i);
    div_chk(11'h004, 3'h6, 12800);
    div_chk(11'h004, 3'h7, 12800);
  endtask
  task t_conv;
    xf(1, 12'h014, 32'h0000_0055);
    xf(1, 12'h018, 32'h0000_0001);
    chk(cg, 8'h55);
  endtask
  task t_dual;
    dual_in_phase_i <= 1;
    repeat (3) @(posedge clk_sys_i);
    chk(clk_out_n_o, clk_out_p_o);
    dual_in_phase_i <= 0;
    repeat (3) @(posedge clk_sys_i);
    chk(clk_out_n_o, !clk_out_p_o);
  endtask
  task t_range;
    xf(1, 12'h008, 32'h0000_07FE);
    xf(1, 12'h018, 32'h0000_0001);
    xf(0, 12'h01C, zero);
    chk(r[0], 0);
    chk(hs, 11'h7FE);
    xf(1, 12'h008, 32'h0000_0003);
    xf(1, 12'h018, 32'h0000_0001);
    xf(0, 12'h01C, zero);
    chk(r[0], 1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1;
    t_reset;
    t_stage;
    t_div;
    t_conv;
    t_dual;
    t_range;
    close_out;
  end
endmodule // tb
